//--- ovr_nco_pkg.sv
// What this block does
// - compare top 8 magnitude bits against two thresholds
// - magnitude from two's complement, most negative saturates
// - flag set when any sample reaches threshold
// - high-threshold flag is lsb of in-phase word
// - low-threshold flag is lsb of quadrature word
// - monitoring period is two to window exponent
// - full power-down disables serial output drivers
// - eight presets, accumulators always running independently
// - source bit picks pins or select field
// - frequency is word times two^-32 times clock
// - mix real samples with active complex exponential
// - full-scale trim held at 0x022 and 0x023
// - offset trim held at 0x025 and 0x026
// - offset trim ignored under background calibration
package ovr_nco_pkg;
    // widths
    localparam int SAMPLE_W = 12;
    localparam int MAG_W = 11;
    localparam int WORD_W = 16;
    localparam int NUM_PRESETS = 8;
    localparam int FREQ_W = 32;
    localparam int PHASE_W = 16;
    localparam int CNT_W = 7;
    localparam int EXP_W = 3;
    localparam int IDX_W = 10;
    localparam int ADDR_W = 12;
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_FULLSCALE_A = 10'h022;
    localparam logic [9:0] IDX_FULLSCALE_B = 10'h023;
    localparam logic [9:0] IDX_OFFSET_A = 10'h025;
    localparam logic [9:0] IDX_OFFSET_B = 10'h026;
    localparam logic [9:0] IDX_PRESET_SOURCE = 10'h20c;
    localparam logic [9:0] IDX_PRESET_INDEX = 10'h20d;
    localparam logic [9:0] IDX_HIGH_THR = 10'h100;
    localparam logic [9:0] IDX_LOW_THR = 10'h101;
    localparam logic [9:0] IDX_WINDOW = 10'h102;
    localparam logic [9:0] IDX_CONTROL = 10'h103;
    localparam logic [9:0] IDX_STATUS = 10'h104;
    localparam logic [9:0] IDX_FREQ_BASE = 10'h300;
    localparam logic [9:0] IDX_PHASE_BASE = 10'h310;
    // field positions
    localparam int SRC_BIT = 0;
    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_BGCAL_BIT = 1;
    localparam int STAT_I_BIT = 0;
    localparam int STAT_Q_BIT = 1;
    localparam int STAT_PRESET_LSB = 2;
    // values after reset
    localparam logic [7:0] RST_TRIM = 8'h00;
    localparam logic [7:0] RST_THR = 8'hff;
    localparam logic [2:0] RST_WINDOW = 3'h0;
    localparam logic [31:0] RST_FREQ = 32'h0000_0000;
    localparam logic [15:0] RST_PHASE = 16'h0000;
    // bus answers and constants
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [10:0] MAG_MAX = 11'h7ff;
    localparam logic [11:0] TC_MOST_NEG = 12'h800;
    // cosine table, 16 steps per turn, signed 8 bit, entry 0 lowest
    localparam logic [127:0] COS_TAB = {
        8'h75, 8'h5a, 8'h31, 8'h00, 8'hcf, 8'ha6, 8'h8b, 8'h81,
        8'h8b, 8'ha6, 8'hcf, 8'h00, 8'h31, 8'h5a, 8'h75, 8'h7f};
    localparam logic [3:0] QUARTER_TURN = 4'h4;

    typedef struct packed {
        logic [WORD_W-1:0] i;
        logic [WORD_W-1:0] q;
    } iq_word_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic [EXP_W-1:0] exp;
    } ovr_cfg_t;

    typedef struct packed {
        logic inphase;
        logic quadrature;
    } ovr_flags_t;
endpackage

//--- overrange_monitor.sv
`timescale 1ns/1ps
module overrange_monitor
    import ovr_nco_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // raw offset-binary sample and settings
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire ovr_cfg_t cfg,
    // flags of the last completed period
    output ovr_flags_t flags
);
    logic [SAMPLE_W-1:0] twos; // two's-complement view
    logic [SAMPLE_W-1:0] negated; // negative value made positive
    logic [MAG_W-1:0] mag; // magnitude, saturated
    logic [7:0] top; // compared bits
    logic hit_hi;
    logic hit_lo;
    logic [CNT_W-1:0] last_cnt; // period length minus one
    logic period_last;
    logic [CNT_W-1:0] cnt_ff;
    logic acc_hi_ff; // any hit so far in this period
    logic acc_lo_ff;
    ovr_flags_t flags_ff;

    // flipping the msb turns offset binary into two's complement
    assign twos = {~sample_in[SAMPLE_W-1], sample_in[SAMPLE_W-2:0]};
    assign negated = 12'h000 - twos;

    // most negative code would overflow 11 bits, so clamp it
    always_comb begin
        if (!twos[SAMPLE_W-1]) begin
            mag = twos[MAG_W-1:0];
        end else if (twos == TC_MOST_NEG) begin
            mag = MAG_MAX;
        end else begin
            mag = negated[MAG_W-1:0];
        end
    end

    assign top = mag[MAG_W-1:MAG_W-8];
    assign hit_hi = top >= cfg.high;
    assign hit_lo = top >= cfg.low;

    // period end; the >= guards a shrink of the window mid-period
    assign last_cnt = CNT_W'((8'h01 << cfg.exp) - 8'h01);
    assign period_last = cnt_ff >= last_cnt;

    // sample counter of the period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= '0;
        end else if (ce) begin
            cnt_ff <= period_last ? '0 : cnt_ff + 1'b1;
        end
    end

    // running or-accumulation, restarted at each period end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_hi_ff <= 1'b0;
            acc_lo_ff <= 1'b0;
        end else if (ce) begin
            acc_hi_ff <= period_last ? 1'b0 : (acc_hi_ff | hit_hi);
            acc_lo_ff <= period_last ? 1'b0 : (acc_lo_ff | hit_lo);
        end
    end

    // published flags change only at a period end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= '0;
        end else if (ce && period_last) begin
            flags_ff.inphase <= acc_hi_ff | hit_hi;
            flags_ff.quadrature <= acc_lo_ff | hit_lo;
        end
    end

    assign flags = flags_ff;

    chk_mag_saturate: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (sample_in == 12'h000) |-> (mag == MAG_MAX))
        else $error("most negative code did not saturate");
    chk_period_single: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (cfg.exp == 3'h0) |-> period_last)
        else $error("window of one sample did not end each sample");
    chk_flag_set: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && period_last && hit_hi) |=> flags.inphase)
        else $error("high flag missed a hit");
    chk_flag_clear: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (ce && period_last && !hit_lo && !acc_lo_ff)
        |=> !flags.quadrature)
        else $error("low flag not cleared after quiet period");
    cov_high_hit: cover property (@(posedge aclk) disable iff (!aresetn)
        ce && period_last && hit_hi);
endmodule

//--- preset_accumulator.sv
`timescale 1ns/1ps
module preset_accumulator
    import ovr_nco_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // preset settings
    input wire logic [FREQ_W-1:0] freq_word,
    input wire logic [PHASE_W-1:0] phase_offset,
    // accumulated phase with offset
    output logic [FREQ_W-1:0] phase_out
);
    logic [FREQ_W-1:0] acc_ff; // free-running phase

    // wraps modulo 2^32, so the step is word * 2^-32 of a turn
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff <= '0;
        end else if (ce) begin
            acc_ff <= acc_ff + freq_word;
        end
    end

    // offset is left-justified into the 32-bit phase
    assign phase_out = acc_ff + {phase_offset, 16'h0000};

    chk_acc_step: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ce |=> acc_ff == $past(acc_ff) + $past(freq_word))
        else $error("accumulator did not step by the frequency word");
endmodule

//--- overrange_and_nco_preset_select.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module overrange_and_nco_preset_select
    import ovr_nco_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // converter samples, same clock
    input wire logic [SAMPLE_W-1:0] sample_in,
    // preset select pins, asynchronous
    input wire logic [2:0] preset_select_pins,
    // mixed output toward the serial link
    output iq_word_t iq_out,
    output logic iq_valid,
    output logic serial_drv_en,
    // analog trims
    output logic [15:0] fullscale_trim,
    output logic [15:0] input_offset_trim
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // bus state
    logic aw_hold_ff; // write address taken
    logic w_hold_ff; // write data taken
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic do_write; // both halves present
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] nxt_rdata;

    // software-visible state
    logic [7:0] fs_a_ff;
    logic [7:0] fs_b_ff;
    logic [7:0] off_a_ff;
    logic [7:0] off_b_ff;
    logic src_ff; // 1 selects the register field
    logic [2:0] sel_ff;
    logic [7:0] high_thr_ff;
    logic [7:0] low_thr_ff;
    logic [EXP_W-1:0] window_ff;
    logic pd_ff; // full power-down
    logic bgcal_ff; // background calibration enabled
    logic [FREQ_W-1:0] freq_ff [NUM_PRESETS];
    logic [PHASE_W-1:0] phase_ff [NUM_PRESETS];

    // datapath
    logic [2:0] pins_meta_ff; // first sync stage, read only by next
    logic [2:0] pins_sync_ff;
    logic [2:0] active_ff;
    logic [FREQ_W-1:0] preset_phase [NUM_PRESETS];
    logic [FREQ_W-1:0] phase_sel_ff;
    logic [SAMPLE_W-1:0] sample_d_ff; // aligned with phase_sel_ff
    logic signed [SAMPLE_W-1:0] samp_tc;
    logic [3:0] step_cos;
    logic [3:0] step_sin;
    logic signed [7:0] cos_v;
    logic signed [7:0] sin_v;
    logic signed [19:0] prod_i;
    logic signed [19:0] prod_q;
    ovr_flags_t flags;
    ovr_cfg_t cfg;
    iq_word_t iq_ff;
    logic iq_valid_ff;
    logic [15:0] offset_eff_ff;

    // byte-lane merge under write strobes
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // handshakes are frozen together with the state by ce
    assign awready = ce && !aw_hold_ff && !bvalid_ff;
    assign wready = ce && !w_hold_ff && !bvalid_ff;
    assign arready = ce && !rvalid_ff;
    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign widx = awaddr_ff[ADDR_W-1:2];
    assign ridx = araddr[ADDR_W-1:2];

    // write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end else if (do_write) begin
                aw_hold_ff <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end else if (do_write) begin
                w_hold_ff <= 1'b0;
            end
        end
    end

    // write decode; an unmapped index answers slverr
    always_comb begin
        wr_hit = 1'b1;
        unique case (widx)
            IDX_FULLSCALE_A, IDX_FULLSCALE_B, IDX_OFFSET_A,
            IDX_OFFSET_B, IDX_PRESET_SOURCE, IDX_PRESET_INDEX,
            IDX_HIGH_THR, IDX_LOW_THR, IDX_WINDOW, IDX_CONTROL: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = (widx[IDX_W-1:3] == IDX_FREQ_BASE[IDX_W-1:3]) ||
                    (widx[IDX_W-1:3] == IDX_PHASE_BASE[IDX_W-1:3]);
            end
        endcase
    end

    // write response, one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // control registers; status is read-only so writes fall through
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_a_ff <= RST_TRIM;
            fs_b_ff <= RST_TRIM;
            off_a_ff <= RST_TRIM;
            off_b_ff <= RST_TRIM;
            src_ff <= 1'b0;
            sel_ff <= 3'h0;
            high_thr_ff <= RST_THR;
            low_thr_ff <= RST_THR;
            window_ff <= RST_WINDOW;
            pd_ff <= 1'b0;
            bgcal_ff <= 1'b0;
        end else if (ce && do_write && wstrb_ff[0]) begin
            unique case (widx)
                IDX_FULLSCALE_A: fs_a_ff <= wdata_ff[7:0];
                IDX_FULLSCALE_B: fs_b_ff <= wdata_ff[7:0];
                IDX_OFFSET_A: off_a_ff <= wdata_ff[7:0];
                IDX_OFFSET_B: off_b_ff <= wdata_ff[7:0];
                IDX_PRESET_SOURCE: src_ff <= wdata_ff[SRC_BIT];
                IDX_PRESET_INDEX: sel_ff <= wdata_ff[2:0];
                IDX_HIGH_THR: high_thr_ff <= wdata_ff[7:0];
                IDX_LOW_THR: low_thr_ff <= wdata_ff[7:0];
                IDX_WINDOW: window_ff <= wdata_ff[EXP_W-1:0];
                IDX_CONTROL: begin
                    pd_ff <= wdata_ff[CTRL_PD_BIT];
                    bgcal_ff <= wdata_ff[CTRL_BGCAL_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // per-preset frequency and phase words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int n = 0; n < NUM_PRESETS; n++) begin
                freq_ff[n] <= RST_FREQ;
                phase_ff[n] <= RST_PHASE;
            end
        end else if (ce && do_write) begin
            if (widx[IDX_W-1:3] == IDX_FREQ_BASE[IDX_W-1:3]) begin
                freq_ff[widx[2:0]] <=
                    merge(freq_ff[widx[2:0]], wdata_ff, wstrb_ff);
            end
            if (widx[IDX_W-1:3] == IDX_PHASE_BASE[IDX_W-1:3]) begin
                phase_ff[widx[2:0]] <= PHASE_W'(merge({16'h0000,
                    phase_ff[widx[2:0]]}, wdata_ff, wstrb_ff));
            end
        end
    end

    // read mux; unmapped reads return zero with slverr
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (ridx)
            IDX_FULLSCALE_A: nxt_rdata[7:0] = fs_a_ff;
            IDX_FULLSCALE_B: nxt_rdata[7:0] = fs_b_ff;
            IDX_OFFSET_A: nxt_rdata[7:0] = off_a_ff;
            IDX_OFFSET_B: nxt_rdata[7:0] = off_b_ff;
            IDX_PRESET_SOURCE: nxt_rdata[SRC_BIT] = src_ff;
            IDX_PRESET_INDEX: nxt_rdata[2:0] = sel_ff;
            IDX_HIGH_THR: nxt_rdata[7:0] = high_thr_ff;
            IDX_LOW_THR: nxt_rdata[7:0] = low_thr_ff;
            IDX_WINDOW: nxt_rdata[EXP_W-1:0] = window_ff;
            IDX_CONTROL: begin
                nxt_rdata[CTRL_PD_BIT] = pd_ff;
                nxt_rdata[CTRL_BGCAL_BIT] = bgcal_ff;
            end
            IDX_STATUS: begin
                nxt_rdata[STAT_I_BIT] = flags.inphase;
                nxt_rdata[STAT_Q_BIT] = flags.quadrature;
                nxt_rdata[STAT_PRESET_LSB +: 3] = active_ff;
            end
            default: begin
                if (ridx[IDX_W-1:3] == IDX_FREQ_BASE[IDX_W-1:3]) begin
                    nxt_rdata = freq_ff[ridx[2:0]];
                end else if (ridx[IDX_W-1:3] ==
                        IDX_PHASE_BASE[IDX_W-1:3]) begin
                    nxt_rdata[15:0] = phase_ff[ridx[2:0]];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // read answer, registered on the cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= nxt_rdata;
                rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;

    // over-range monitor
    assign cfg = '{high: high_thr_ff, low: low_thr_ff, exp: window_ff};
    overrange_monitor u_monitor (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .sample_in(sample_in),
        .cfg(cfg),
        .flags(flags)
    );

    // all eight accumulators run whatever preset is active
    for (genvar g = 0; g < NUM_PRESETS; g++) begin : g_preset
        preset_accumulator u_acc (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .freq_word(freq_ff[g]),
            .phase_offset(phase_ff[g]),
            .phase_out(preset_phase[g])
        );
    end

    // pins are asynchronous, two stages before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_meta_ff <= 3'h0;
            pins_sync_ff <= 3'h0;
        end else if (ce) begin
            pins_meta_ff <= preset_select_pins;
            pins_sync_ff <= pins_meta_ff;
        end
    end

    // active preset, then its phase; switching costs no settling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_ff <= 3'h0;
            phase_sel_ff <= '0;
            sample_d_ff <= '0;
        end else if (ce) begin
            active_ff <= src_ff ? sel_ff : pins_sync_ff;
            phase_sel_ff <= preset_phase[active_ff];
            sample_d_ff <= sample_in;
        end
    end

    // coarse 16-step lookup keeps area small at the cost of spurs
    assign samp_tc = {~sample_d_ff[SAMPLE_W-1],
        sample_d_ff[SAMPLE_W-2:0]};
    assign step_cos = phase_sel_ff[FREQ_W-1 -: 4];
    assign step_sin = step_cos - QUARTER_TURN;
    assign cos_v = COS_TAB[8*step_cos +: 8];
    assign sin_v = COS_TAB[8*step_sin +: 8];
    // multiplying by exp(-jwn) moves the carrier down to 0 Hz
    assign prod_i = samp_tc * cos_v;
    assign prod_q = -(samp_tc * sin_v);

    // output words: 15 data bits with the flag below them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iq_ff <= '0;
            iq_valid_ff <= 1'b0;
        end else if (ce) begin
            iq_ff.i <= {prod_i[18:4], flags.inphase};
            iq_ff.q <= {prod_q[18:4], flags.quadrature};
            iq_valid_ff <= !pd_ff;
        end
    end

    // offset trim forced to zero while background calibration runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            offset_eff_ff <= '0;
        end else if (ce) begin
            offset_eff_ff <= bgcal_ff ? 16'h0000 :
                {off_b_ff, off_a_ff};
        end
    end

    assign iq_out = iq_ff;
    assign iq_valid = iq_valid_ff;
    assign serial_drv_en = !pd_ff;
    assign fullscale_trim = {fs_b_ff, fs_a_ff};
    assign input_offset_trim = offset_eff_ff;

    chk_i_lsb: assert property (ce |=>
        iq_out.i[0] == $past(flags.inphase))
        else $error("in-phase lsb is not the high flag");
    chk_q_lsb: assert property (ce |=>
        iq_out.q[0] == $past(flags.quadrature))
        else $error("quadrature lsb is not the low flag");
    // drivers follow the bit at once, valid one cycle later
    chk_pd_drivers: assert property ((ce && pd_ff) |->
        !serial_drv_en ##1 !iq_valid)
        else $error("output active during power-down");
    chk_pin_select: assert property ((ce && !src_ff) |=>
        active_ff == $past(pins_sync_ff))
        else $error("pins did not pick the preset");
    chk_field_select: assert property ((ce && src_ff) |=>
        active_ff == $past(sel_ff))
        else $error("field did not pick the preset");
    chk_offset_ignored: assert property ((ce && bgcal_ff) |=>
        input_offset_trim == 16'h0000)
        else $error("offset trim applied under calibration");
    cov_write_done: cover property (bvalid && bready && ce);
    cov_preset_switch: cover property (ce && active_ff != $past(active_ff));
endmodule

//--- link_sink.sv
`timescale 1ns/1ps
module link_sink
    import ovr_nco_pkg::*;
(
    // sample clock
    input wire logic aclk,
    // link side of the block
    input wire logic iq_valid,
    input wire logic serial_drv_en,
    // words accepted after the flush
    output int kept
);
    int skip = 4; // stale pipeline words still to drop
    initial kept = 0;
    // drivers off means the link is gone, so relink and drop stale words
    always @(posedge aclk) begin
        if (!serial_drv_en) begin
            skip <= 4;
        end else if (iq_valid && skip > 0) begin
            skip <= skip - 1;
        end else if (iq_valid) begin
            kept <= kept + 1;
        end
    end
endmodule

//--- tb_overrange_and_nco_preset_select.sv
`timescale 1ns/1ps
module tb_overrange_and_nco_preset_select
    import ovr_nco_pkg::*;
;
    logic aclk = 0, aresetn = 0, ce = 1, bready = 1, rready = 1;
    logic awvalid = 0, wvalid = 0, arvalid = 0;
    logic [11:0] awaddr = 0, araddr = 0, sample_in = 12'h800;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic [2:0] preset_select_pins = 0;
    logic awready, wready, bvalid, arready, rvalid, iq_valid, serial_drv_en;
    logic [1:0] bresp, rresp, r;
    logic [15:0] fullscale_trim, input_offset_trim;
    iq_word_t iq_out;
    int num_errors = 0, samples_checked = 0, kept, hits;
    overrange_and_nco_preset_select uut (.aclk, .aresetn, .ce, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .sample_in, .preset_select_pins, .iq_out,
        .iq_valid, .serial_drv_en, .fullscale_trim, .input_offset_trim);
    link_sink sink (.aclk, .iq_valid, .serial_drv_en, .kept);
    always #10 aclk = ~aclk;
    function automatic logic [11:0] a(input logic [9:0] i);
        return {i, 2'h0};
    endfunction
    task automatic cmp(input string n, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // both halves offered together, each dropped once taken
    task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
        bit aw_done = 0, w_done = 0;
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready && !aw_done) begin
                aw_done = 1;
                awvalid <= 1'h0;
            end
            if (wready && !w_done) begin
                w_done = 1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        cmp("bresp", RESP_OKAY, bresp);
    endtask
    task automatic rd(input logic [11:0] ad);
        araddr <= ad;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    task automatic t_preset();
        for (int k = 0; k < 8; k++) begin
            preset_select_pins <= 3'(k);
            repeat (5) @(posedge aclk);
            rd(a(IDX_STATUS));
            cmp("pins", k, d[4:2]);
        end
        wr(a(IDX_PRESET_SOURCE), 32'h1);
        wr(a(IDX_PRESET_INDEX), 32'h2);
        rd(a(IDX_STATUS));
        cmp("field", 32'h2, d[4:2]);
    endtask
    task automatic t_trim();
        wr(a(IDX_FULLSCALE_A), 32'h34);
        wr(a(IDX_FULLSCALE_B), 32'h12);
        wr(a(IDX_OFFSET_A), 32'h78);
        wr(a(IDX_OFFSET_B), 32'h56);
        cmp("fs", 32'h1234, fullscale_trim);
        // the effective offset is registered one cycle behind
        @(posedge aclk);
        cmp("off", 32'h5678, input_offset_trim);
        wr(a(IDX_CONTROL), 32'h2);
        repeat (2) @(posedge aclk);
        cmp("bgcal", 32'h0, input_offset_trim);
        wr(a(IDX_CONTROL), 32'h0);
        rd(12'hffc);
        cmp("unmapped", RESP_SLVERR, r);
    endtask
    // steady samples with a one-sample period give steady flags
    task automatic t_mag(input logic [11:0] s, input logic [1:0] e);
        sample_in <= s;
        repeat (6) @(posedge aclk);
        cmp("flags", e, {iq_out.i[0], iq_out.q[0]});
        // active preset sits at phase zero, so the sine term is nil
        cmp("qdata", 32'h0, iq_out.q[15:1]);
    endtask
    task automatic t_window();
        wr(a(IDX_WINDOW), 32'h3);
        repeat (20) @(posedge aclk);
        sample_in <= 12'h000;
        @(posedge aclk);
        sample_in <= 12'h800;
        hits = 0;
        repeat (30) begin
            @(posedge aclk);
            hits += iq_out.i[0];
        end
        cmp("period", 32'h8, hits);
    endtask
    task automatic t_pd();
        wr(a(IDX_FREQ_BASE), 32'h1000_0000);
        rd(a(IDX_FREQ_BASE));
        cmp("freq", 32'h1000_0000, d);
        // a frequency change leaves the phase open, so relink
        wr(a(IDX_CONTROL), 32'h1);
        repeat (2) @(posedge aclk);
        cmp("drv", 32'h0, serial_drv_en);
        cmp("valid", 32'h0, iq_valid);
        wr(a(IDX_CONTROL), 32'h0);
        repeat (2) @(posedge aclk);
        cmp("drv", 32'h1, serial_drv_en);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_preset();
        t_trim();
        t_mag(12'h000, 2'h3);
        t_mag(12'h800, 2'h0);
        wr(a(IDX_LOW_THR), 32'h2);
        t_mag(12'h80f, 2'h0);
        t_mag(12'h817, 2'h1);
        t_mag(12'h010, 2'h1);
        t_window();
        t_pd();
        print_verdict();
    end
    // hang guard, far above the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end
endmodule
